// ---- rtl/ecl_params.svh ----
// constants of the eeprom configuration loader
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH
`define ECL_CORE_CLK_KHZ 25000
`define ECL_SYS_CLK_KHZ 100000
`define ECL_SCK_KHZ 8330
`define ECL_SCK_DIV (`ECL_CORE_CLK_KHZ / `ECL_SCK_KHZ)
`define ECL_MODE_SPI 2'h1
`define ECL_RD_INSTR 8'h03
`define ECL_START_ADDR 16'h0000
`define ECL_REC_BASE 16'h0180
`define ECL_LAST_ADDR 16'h019b
`define ECL_REC_ADDR_LO 3'h4
`define ECL_REC_ADDR_HI 3'h5
`define ECL_REC_CMD_OFF 3'h6
`define ECL_CMD_WRITE 8'h01
`define ECL_DRAIN_LAST 2'h2
`endif

// ---- rtl/ecl_pkg.sv ----
// types of the eeprom configuration loader
package ecl_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_CMD = 7'h02,
		ST_ADDH = 7'h04,
		ST_ADDL = 7'h08,
		ST_DATA = 7'h10,
		ST_MACW = 7'h20,
		ST_DONE = 7'h40
	} ecl_state_t;
	typedef enum logic [2:0] {
		SH_IDLE = 3'h1,
		SH_RUN = 3'h2,
		SH_DRAIN = 3'h4
	} ecl_sh_state_t;
endpackage

// ---- rtl/ecl_shift_if.sv ----
// byte shift request and answer between sequencer and serial engine
`timescale 1ns/1ps
`default_nettype none
interface ecl_shift_if;
	logic start;
	logic abort;
	logic out_rise;
	logic smp_rise;
	logic [7:0] tx_byte;
	logic done;
	logic [7:0] rx_byte;
	logic sck;
	logic mosi;
	modport ctrl(output start, abort, out_rise, smp_rise, tx_byte, input done, rx_byte, sck, mosi);
	modport eng(input start, abort, out_rise, smp_rise, tx_byte, output done, rx_byte, sck, mosi);
endinterface
`default_nettype wire

// ---- rtl/ecl_shifter.sv ----
// serial engine: divided clock, one byte out and in per request
`timescale 1ns/1ps
`default_nettype none
`include "ecl_params.svh"
module ecl_shifter import ecl_pkg::*; #(
	parameter int SCK_DIV = `ECL_SCK_DIV
) (
	// system
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// eeprom data in
	input wire logic miso_i,
	// sequencer side
	ecl_shift_if.eng sh
);
	localparam int HI = SCK_DIV / 2;
	localparam logic [7:0] PH_LAST = 8'(SCK_DIV - 1);
	localparam logic [7:0] PH_FALL = 8'(HI - 1);

	ecl_sh_state_t st_reg, st_next;
	logic [7:0] ph_reg, ph_next, tx_reg, tx_next, rx_reg, rx_next;
	logic [2:0] bit_reg, bit_next;
	logic [1:0] smp_reg, smp_next, dr_reg, dr_next;
	logic sck_reg, sck_next, mosi_reg, mosi_next;
	logic miso_m, miso_s;
	logic rise, fall;

	assign rise = (st_reg == SH_RUN) && (ph_reg == PH_LAST);
	assign fall = (st_reg == SH_RUN) && (ph_reg == PH_FALL);
	assign sh.done = (st_reg == SH_DRAIN) && (dr_reg == `ECL_DRAIN_LAST);
	assign sh.rx_byte = rx_reg;
	assign sh.sck = sck_reg;
	assign sh.mosi = mosi_reg;

	always_comb begin
		st_next = st_reg;
		ph_next = ph_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		bit_next = bit_reg;
		dr_next = dr_reg;
		sck_next = sck_reg;
		mosi_next = mosi_reg;
		smp_next = {smp_reg[0], 1'b0};
		unique case (st_reg)
			SH_IDLE: if (sh.start) begin
				st_next = SH_RUN;
				ph_next = PH_LAST;
				bit_next = 3'h0;
				tx_next = sh.tx_byte;
				mosi_next = sh.tx_byte[7];
			end
			SH_RUN: begin
				ph_next = rise ? 8'h00 : ph_reg + 8'h01;
				if (rise) begin
					sck_next = 1'b1;
					if (sh.out_rise)
						mosi_next = tx_reg[3'h7 - bit_reg];
					if (sh.smp_rise)
						smp_next[0] = 1'b1;
				end
				if (fall) begin
					sck_next = 1'b0;
					if (!sh.out_rise && bit_reg != 3'h7)
						mosi_next = tx_reg[3'h6 - bit_reg];
					if (!sh.smp_rise)
						smp_next[0] = 1'b1;
					bit_next = bit_reg + 3'h1;
					if (bit_reg == 3'h7) begin
						st_next = SH_DRAIN;
						dr_next = 2'h0;
					end
				end
			end
			SH_DRAIN: begin
				dr_next = dr_reg + 2'h1;
				if (dr_reg == `ECL_DRAIN_LAST)
					st_next = SH_IDLE;
			end
		endcase
		// synchroniser latency is made up by delaying the sample point
		if (smp_reg[1])
			rx_next = {rx_reg[6:0], miso_s};
		if (sh.abort) begin
			// data out must not move on an abort, the clock edge it belongs to is cancelled
			st_next = SH_IDLE;
			sck_next = 1'b0;
			mosi_next = mosi_reg;
			smp_next = 2'h0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= SH_IDLE;
			ph_reg <= 8'h00;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			bit_reg <= 3'h0;
			dr_reg <= 2'h0;
			sck_reg <= 1'b0;
			mosi_reg <= 1'b0;
			smp_reg <= 2'h0;
			miso_m <= 1'b0;
			miso_s <= 1'b0;
		end else begin
			st_reg <= st_next;
			ph_reg <= ph_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			bit_reg <= bit_next;
			dr_reg <= dr_next;
			sck_reg <= sck_next;
			mosi_reg <= mosi_next;
			smp_reg <= smp_next;
			miso_m <= miso_i;
			miso_s <= miso_m;
		end
	end

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	AST_SCK_HIGH: assert property ($rose(sh.sck) |=> $fell(sh.sck))
		else $error("serial clock high phase wrong");
	AST_BYTE_LEN: assert property (@(posedge core_clk_i) disable iff (!rstn_i || sh.abort)
		(sh.start && st_reg == SH_IDLE) |-> ##26 sh.done)
		else $error("byte did not finish in 26 cycles");
	AST_MOSI_EDGE: assert property (($past(st_reg) == SH_RUN && $changed(sh.mosi))
		|-> (sh.out_rise ? $rose(sh.sck) : $fell(sh.sck)))
		else $error("data out changed on wrong clock edge");
endmodule
`default_nettype wire

// ---- rtl/ecl_loader.sv ----
// serial eeprom configuration loader, spi master side
`timescale 1ns/1ps
`default_nettype none
`include "ecl_params.svh"
module ecl_loader import ecl_pkg::*; #(
	parameter int SCK_DIV = `ECL_SCK_DIV
) (
	// system
	input wire logic core_clk_i,
	input wire logic rstn_i,
	// straps and reset pin
	input wire logic [1:0] config_mode_select_i,
	input wire logic sample_phase_select_i,
	input wire logic mosi_edge_select_i,
	input wire logic ext_reset_n_i,
	// eeprom link
	output logic loader_serial_clock_o,
	output logic spi_cs_n_o,
	output logic spi_mosi_o,
	input wire logic spi_miso_i,
	// direct register writes
	output logic cfg_wr_o,
	output logic [8:0] cfg_addr_o,
	output logic [7:0] cfg_data_o,
	// indirect mac access
	output logic [31:0] indirect_write_data_o,
	output logic [7:0] indirect_address_low_o,
	output logic [7:0] indirect_address_high_o,
	output logic [7:0] indirect_command_o,
	output logic mac_wr_start_o,
	input wire logic mac_wr_done_i,
	// status
	output logic load_busy_o,
	output logic load_done_o
);
	ecl_shift_if sh_if();

	ecl_shifter #(.SCK_DIV(SCK_DIV)) u_shift (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.miso_i(spi_miso_i),
		.sh(sh_if.eng)
	);

	// pin synchronisers: {reset pin, out edge, sample edge, mode}
	logic [4:0] sy1_reg, sy2_reg;
	logic ext_dly_reg;
	logic mode_spi, ext_rst_s, ext_rise;

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			// reset pin synced as released high, matching ext_dly_reg: no false restart edge
			sy1_reg <= 5'h10;
			sy2_reg <= 5'h10;
			ext_dly_reg <= 1'b1;
		end else begin
			sy1_reg <= {ext_reset_n_i, mosi_edge_select_i, sample_phase_select_i, config_mode_select_i};
			sy2_reg <= sy1_reg;
			ext_dly_reg <= sy2_reg[4];
		end
	end

	assign mode_spi = (sy2_reg[1:0] == `ECL_MODE_SPI);
	assign ext_rst_s = sy2_reg[4];
	assign ext_rise = ext_rst_s && !ext_dly_reg;

	ecl_state_t st_reg, st_next;
	logic [15:0] addr_reg, addr_next, addr_inc;
	logic [2:0] roff_reg, roff_next;
	logic pend_reg, pend_next, cs_reg, cs_next, start_reg, start_next;
	logic [7:0] tx_reg, tx_next;
	logic wr_reg, wr_next, mstart_reg, mstart_next;
	logic [8:0] wa_reg, wa_next;
	logic [7:0] wd_reg, wd_next, ial_reg, ial_next, iah_reg, iah_next, icmd_reg, icmd_next;
	logic [31:0] iwd_reg, iwd_next;
	logic in_rec, launch, rx_done;

	assign addr_inc = addr_reg + 16'h0001;
	assign rx_done = sh_if.done;
	assign in_rec = (addr_reg >= `ECL_REC_BASE);
	assign launch = in_rec && (roff_reg == `ECL_REC_CMD_OFF) && (sh_if.rx_byte == `ECL_CMD_WRITE);

	assign sh_if.start = start_reg;
	assign sh_if.tx_byte = tx_reg;
	assign sh_if.abort = ext_rise;
	assign sh_if.out_rise = sy2_reg[3];
	assign sh_if.smp_rise = sy2_reg[2];

	always_comb begin
		st_next = st_reg;
		addr_next = addr_reg;
		roff_next = roff_reg;
		pend_next = pend_reg;
		cs_next = cs_reg;
		tx_next = tx_reg;
		wa_next = wa_reg;
		wd_next = wd_reg;
		ial_next = ial_reg;
		iah_next = iah_reg;
		icmd_next = icmd_reg;
		iwd_next = iwd_reg;
		start_next = 1'b0;
		wr_next = 1'b0;
		mstart_next = 1'b0;
		if (ext_rise)
			pend_next = 1'b1;
		unique case (st_reg)
			// a pin rise in this cycle keeps pending set and starts one cycle later
			ST_IDLE: if (pend_reg && mode_spi && ext_rst_s && !ext_rise) begin
				st_next = ST_CMD;
				cs_next = 1'b0;
				start_next = 1'b1;
				tx_next = `ECL_RD_INSTR;
				addr_next = `ECL_START_ADDR;
				roff_next = 3'h0;
				pend_next = 1'b0;
			end
			ST_CMD: if (rx_done) begin
				st_next = ST_ADDH;
				start_next = 1'b1;
				tx_next = addr_reg[15:8];
			end
			ST_ADDH: if (rx_done) begin
				st_next = ST_ADDL;
				start_next = 1'b1;
				tx_next = addr_reg[7:0];
			end
			ST_ADDL: if (rx_done) begin
				st_next = ST_DATA;
				start_next = 1'b1;
				tx_next = 8'h00;
			end
			ST_DATA: if (rx_done) begin
				if (!in_rec) begin
					wr_next = 1'b1;
					wa_next = addr_reg[8:0];
					wd_next = sh_if.rx_byte;
				end else begin
					case (roff_reg)
						3'h0: iwd_next[7:0] = sh_if.rx_byte;
						3'h1: iwd_next[15:8] = sh_if.rx_byte;
						3'h2: iwd_next[23:16] = sh_if.rx_byte;
						3'h3: iwd_next[31:24] = sh_if.rx_byte;
						`ECL_REC_ADDR_LO: ial_next = sh_if.rx_byte;
						`ECL_REC_ADDR_HI: iah_next = sh_if.rx_byte;
						default: icmd_next = sh_if.rx_byte;
					endcase
					// seven-byte records wrap on the command byte
					roff_next = (roff_reg == `ECL_REC_CMD_OFF) ? 3'h0 : roff_reg + 3'h1;
				end
				if (launch) begin
					mstart_next = 1'b1;
					st_next = ST_MACW;
				end else if (addr_reg == `ECL_LAST_ADDR) begin
					st_next = ST_DONE;
					cs_next = 1'b1;
				end else begin
					addr_next = addr_inc;
					start_next = 1'b1;
					tx_next = 8'h00;
				end
			end
			// serial clock is parked while the mac write runs
			ST_MACW: if (mac_wr_done_i) begin
				if (addr_reg == `ECL_LAST_ADDR) begin
					st_next = ST_DONE;
					cs_next = 1'b1;
				end else begin
					st_next = ST_DATA;
					addr_next = addr_inc;
					start_next = 1'b1;
					tx_next = 8'h00;
				end
			end
			ST_DONE: if (pend_reg)
				st_next = ST_IDLE;
		endcase
		// a reset pin rise aborts a load in flight and restarts it
		if (ext_rise && st_reg != ST_IDLE && st_reg != ST_DONE) begin
			st_next = ST_IDLE;
			cs_next = 1'b1;
			start_next = 1'b0;
			wr_next = 1'b0;
			mstart_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			st_reg <= ST_IDLE;
			addr_reg <= 16'h0000;
			roff_reg <= 3'h0;
			pend_reg <= 1'b1;
			cs_reg <= 1'b1;
			start_reg <= 1'b0;
			tx_reg <= 8'h00;
			wr_reg <= 1'b0;
			wa_reg <= 9'h000;
			wd_reg <= 8'h00;
			iwd_reg <= 32'h0000_0000;
			ial_reg <= 8'h00;
			iah_reg <= 8'h00;
			icmd_reg <= 8'h00;
			mstart_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			addr_reg <= addr_next;
			roff_reg <= roff_next;
			pend_reg <= pend_next;
			cs_reg <= cs_next;
			start_reg <= start_next;
			tx_reg <= tx_next;
			wr_reg <= wr_next;
			wa_reg <= wa_next;
			wd_reg <= wd_next;
			iwd_reg <= iwd_next;
			ial_reg <= ial_next;
			iah_reg <= iah_next;
			icmd_reg <= icmd_next;
			mstart_reg <= mstart_next;
		end
	end

	assign loader_serial_clock_o = sh_if.sck;
	assign spi_mosi_o = sh_if.mosi;
	assign spi_cs_n_o = cs_reg;
	assign cfg_wr_o = wr_reg;
	assign cfg_addr_o = wa_reg;
	assign cfg_data_o = wd_reg;
	assign indirect_write_data_o = iwd_reg;
	assign indirect_address_low_o = ial_reg;
	assign indirect_address_high_o = iah_reg;
	assign indirect_command_o = icmd_reg;
	assign mac_wr_start_o = mstart_reg;
	assign load_busy_o = !cs_reg;
	assign load_done_o = (st_reg == ST_DONE);

	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);

	AST_MODE_GATE: assert property ($fell(spi_cs_n_o) |-> $past(mode_spi))
		else $error("load started outside serial mode");
	AST_FIRST_INSTR: assert property ($fell(spi_cs_n_o) |-> sh_if.start && sh_if.tx_byte == 8'h03)
		else $error("transaction did not open with read instruction");
	AST_START_ZERO: assert property ($fell(spi_cs_n_o) |-> addr_reg == 16'h0000)
		else $error("read did not start at address zero");
	AST_CS_HELD: assert property (((st_reg == ST_DATA && !(rx_done && !launch && addr_reg == 16'h019b))
		|| (st_reg == ST_MACW && !(mac_wr_done_i && addr_reg == 16'h019b))) && !ext_rise |=> !spi_cs_n_o)
		else $error("select released before last byte latched");
	AST_ADDR_STEP: assert property ((st_reg == ST_DATA && $past(st_reg) != ST_ADDL && $changed(addr_reg))
		|-> addr_reg == $past(addr_reg) + 16'h0001)
		else $error("address did not advance by one");
	AST_DIRECT_ONLY: assert property (cfg_wr_o |-> cfg_addr_o < 9'h180)
		else $error("direct write outside register regions");
	AST_LAUNCH_CMD: assert property (mac_wr_start_o |-> indirect_command_o == 8'h01 && $past(roff_reg) == 3'h6)
		else $error("mac write launched without write command");
	AST_MAC_HOLD: assert property ((st_reg == ST_MACW && !mac_wr_done_i) |=> !sh_if.start)
		else $error("next record read before mac write finished");
endmodule
`default_nettype wire

// ---- bench/ecl_eeprom_model.sv ----
// serial eeprom model answering one sequential read
`timescale 1ns/1ps
`default_nettype none
module ecl_eeprom_model (
	// link
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic mosi_i,
	output logic miso_o,
	// model's own edge choice, opposite the master's, 1 = rise
	input wire logic in_rise_i,
	input wire logic out_rise_i,
	// protocol fault seen
	output logic link_err_o
);
	logic [7:0] mem [0:511];
	logic [23:0] hdr;
	int n_in;
	int n_out;
	initial begin
		miso_o = 1'b0;
		link_err_o = 1'b0;
		for (int i = 0; i < 512; i++) mem[i] = 8'h00;
	end
	always @(negedge cs_n_i) begin
		n_in = 0;
		n_out = 0;
	end
	// no pull on the line: show the inverse once released
	always @(posedge cs_n_i) miso_o = ~miso_o;
	task automatic take();
		if (!cs_n_i && n_in < 24) begin
			hdr = {hdr[22:0], mosi_i};
			n_in++;
			if (n_in == 24 && {hdr[23:20], hdr[18:0]} !== {4'h0, 3'h3, 16'h0000}) link_err_o = 1'b1;
		end
	endtask
	task automatic give();
		int b;
		n_out++;
		b = n_out - (out_rise_i ? 25 : 24);
		if (!cs_n_i && b >= 0) miso_o = mem[9'(b / 8)][7 - b % 8];
	endtask
	always @(posedge sck_i) begin
		if (in_rise_i) take();
		if (out_rise_i) give();
	end
	always @(negedge sck_i) begin
		if (!in_rise_i) take();
		if (!out_rise_i) give();
	end
endmodule
`default_nettype wire

// ---- bench/ecl_loader_tb_top.sv ----
// self-checking bench of the eeprom configuration loader
`timescale 1ns/1ps
`default_nettype none
`include "ecl_params.svh"
module ecl_loader_tb_top;
	localparam int NRISE = 8 * (3 + `ECL_LAST_ADDR + 1);
	logic clk, rstn, smp, medge, extn, done_in, sck, cs_n, mosi, miso, cfg_wr, mwr, busy, ldone, lerr;
	logic [1:0] mode;
	logic [8:0] caddr;
	logic [7:0] cdata, alo, ahi, cmd;
	logic [31:0] wdata;
	logic sck_q, cs_q, aborting, waiting;
	logic [55:0] last_rec;
	logic [16:0] exp_cfg[$];
	logic [55:0] exp_mac[$];
	int checks, miscompares, gap, hi, rises;
	ecl_loader dut (
		.core_clk_i(clk),
		.rstn_i(rstn),
		.config_mode_select_i(mode),
		.sample_phase_select_i(smp),
		.mosi_edge_select_i(medge),
		.ext_reset_n_i(extn),
		.loader_serial_clock_o(sck),
		.spi_cs_n_o(cs_n),
		.spi_mosi_o(mosi),
		.spi_miso_i(miso),
		.cfg_wr_o(cfg_wr),
		.cfg_addr_o(caddr),
		.cfg_data_o(cdata),
		.indirect_write_data_o(wdata),
		.indirect_address_low_o(alo),
		.indirect_address_high_o(ahi),
		.indirect_command_o(cmd),
		.mac_wr_start_o(mwr),
		.mac_wr_done_i(done_in),
		.load_busy_o(busy),
		.load_done_o(ldone)
	);
	ecl_eeprom_model u_eep (
		.cs_n_i(cs_n),
		.sck_i(sck),
		.mosi_i(mosi),
		.miso_o(miso),
		.in_rise_i(~medge),
		.out_rise_i(~smp),
		.link_err_o(lerr)
	);
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// random image; record 4 carries a non-launch command
	task automatic prep();
		logic [7:0] b;
		exp_cfg.delete();
		exp_mac.delete();
		for (int i = 0; i <= `ECL_LAST_ADDR; i++) begin
			b = 8'($urandom);
			if (i >= `ECL_REC_BASE && (i - `ECL_REC_BASE) % 7 == 6) begin
				b = (i == `ECL_LAST_ADDR) ? 8'h80 : 8'h01;
				last_rec = {u_eep.mem[i-3], u_eep.mem[i-4], u_eep.mem[i-5], u_eep.mem[i-6],
					u_eep.mem[i-1], u_eep.mem[i-2], b};
				if (b == 8'h01) exp_mac.push_back(last_rec);
			end
			u_eep.mem[i] = b;
			if (i < `ECL_REC_BASE) exp_cfg.push_back({9'(i), b});
		end
	endtask
	task automatic finish_load();
		wait (cs_n === 1'b0);
		wait (ldone === 1'b1);
		@(negedge clk);
		check({exp_cfg.size() == 0, exp_mac.size() == 0, cs_n, busy, lerr}, 5'b11100);
		check({wdata, ahi, alo, cmd}, last_rec);
	endtask
	// edge selects change only while the loader is held idle
	task automatic restart(input int sel, input int cut);
		@(posedge clk);
		#1 aborting = 1'b1;
		extn = 1'b0;
		repeat (4) @(posedge clk);
		#1 {medge, smp} = 2'(sel);
		prep();
		repeat (4) @(posedge clk);
		#1 extn = 1'b1;
		wait (cs_n === 1'b1);
		@(posedge clk);
		aborting = 1'b0;
		if (cut > 0) repeat (cut) @(posedge clk);
		else finish_load();
	endtask
	always @(negedge clk) begin
		gap++;
		if (sck === 1'b1) hi++;
		if (sck === 1'b1 && sck_q === 1'b0) begin
			check(gap < 3 || waiting, 0);
			gap = 0;
			rises++;
		end
		if (sck === 1'b0 && sck_q === 1'b1) begin
			check(hi, 1);
			hi = 0;
		end
		if (cs_n === 1'b0 && cs_q === 1'b1) rises = 0;
		if (cs_n === 1'b1 && cs_q === 1'b0 && !aborting) check(rises, NRISE);
		if (cfg_wr === 1'b1 && !aborting) check({caddr, cdata}, exp_cfg.size() > 0 ? exp_cfg.pop_front() : 17'h1ffff);
		if (mwr === 1'b1 && !aborting) check({wdata, ahi, alo, cmd}, exp_mac.size() > 0 ? exp_mac.pop_front() : 56'h0);
		sck_q = sck;
		cs_q = cs_n;
	end
	// mac side answers after a random delay
	initial forever begin
		@(negedge clk);
		if (mwr === 1'b1) begin
			waiting = 1'b1;
			repeat ($urandom_range(1, 12)) @(posedge clk);
			#1 done_in = 1'b1;
			@(posedge clk);
			#1 done_in = 1'b0;
			waiting = 1'b0;
		end
	end
	initial begin
		#3000000;
		miscompares++;
		test_done();
	end
	initial begin
		void'($urandom(82));
		{rstn, mode, smp, medge, done_in, aborting, waiting, sck_q} = 9'h000;
		extn = 1'b1;
		cs_q = 1'b1;
		{checks, miscompares, hi, rises} = 128'h0;
		gap = 100;
		prep();
		repeat (10) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (40) @(posedge clk);
		#1 check({cs_n, busy, sck}, 3'b100);
		mode = 2'h1;
		finish_load();
		restart(1, 0);
		restart(2, 3000);
		restart(2, 0);
		restart(3, 0);
		test_done();
	end
endmodule
`default_nettype wire
